// ===== core/rpe_regs.svh
// Register offsets, field positions, reset values and timing counts of the counter block
`ifndef RPE_REGS_SVH
`define RPE_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses on the plain register port)
// ----------------------------------------------------------------------------
`define RPE_OFS_CONTROL_A     6'h00
`define RPE_OFS_STATUS    6'h01
`define RPE_OFS_INTEN     6'h02
`define RPE_OFS_COUNTER_IRQ_FLAGS  6'h03
`define RPE_OFS_COUNTER_DEBUG_CONTROL   6'h05
`define RPE_OFS_CNT_LO    6'h08
`define RPE_OFS_CNT_HI    6'h09
`define RPE_OFS_PER_LO    6'h0A
`define RPE_OFS_PER_HI    6'h0B
`define RPE_OFS_CMP_LO    6'h0C
`define RPE_OFS_CMP_HI    6'h0D
`define RPE_OFS_TCTRL     6'h10
`define RPE_OFS_TSTATUS   6'h11
`define RPE_OFS_TINTEN    6'h12
`define RPE_OFS_TINTFLAGS 6'h13
`define RPE_OFS_TDBGCTRL  6'h15

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RPE_CONTROL_A_EN      0
`define RPE_CONTROL_A_PRE_LSB 3
`define RPE_CONTROL_A_PRE_MSB 6
`define RPE_CONTROL_A_STDBY   7
`define RPE_TCTRL_EN      0
`define RPE_TCTRL_PER_LSB 3
`define RPE_TCTRL_PER_MSB 6
`define RPE_FLAG_WRAP     0
`define RPE_FLAG_CMP      1
`define RPE_TFLAG_TICK    0
`define RPE_DBG_RUN       0

// ----------------------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------------------
`define RPE_CONTROL_A_RST     8'h00
`define RPE_PER_RST       16'hFFFF
`define RPE_CMP_RST       16'h0000
`define RPE_TCTRL_RST     8'h00
`define RPE_SYNC_TICKS    2'h2
`define RPE_TICK_CODE_MIN 4'h1
`define RPE_TICK_CODE_MAX 4'hE
`define RPE_LEVEL_LSB     5

`endif

// ===== core/rpe_pkg.sv
// Types shared by the counter block and its users
package rpe_pkg;

  // Power and debug state of the surrounding chip
  typedef struct packed {
    logic idle;
    logic standby;
    logic halted;
  } rpe_power_t;

  // Event outputs toward the event routing system
  typedef struct packed {
    logic       wrap_event;
    logic       compare_match;
    logic [7:0] tick_levels;
  } rpe_event_t;

  // Registers whose writes cross into the counter clock
  typedef enum logic [2:0] {
    RPE_SY_CONTROL_A = 3'h0,
    RPE_SY_CNT   = 3'h1,
    RPE_SY_PER   = 3'h2,
    RPE_SY_CMP   = 3'h3,
    RPE_SY_TICK  = 3'h4
  } rpe_sync_t;

endpackage : rpe_pkg

// ===== core/rpe_core.sv
// Real-time counter and periodic tick timer: events, interrupts, sleep, sync and debug
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "rpe_regs.svh"

module rpe_core
  import rpe_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int PRE_W = 15
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // Counter clock pin, sampled on mclk
  input  wire logic       counter_clk_pin,
  // Chip power and debug state
  input  wire rpe_power_t power_state,
  // Register port
  input  wire logic [5:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Interrupt requests, one per vector
  output logic            counter_irq,
  output logic            tick_irq,
  // Events
  output rpe_event_t      events
);

  // --------------------------------------------------------------------------
  // Counter clock recovery
  // --------------------------------------------------------------------------
  logic rclk_s1_reg;
  logic rclk_s2_reg;
  logic rclk_s3_reg;
  logic rtc_tick;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rclk_s1_reg <= 1'b0;
      rclk_s2_reg <= 1'b0;
      rclk_s3_reg <= 1'b0;
    end else begin
      rclk_s1_reg <= counter_clk_pin;
      rclk_s2_reg <= rclk_s1_reg;
      rclk_s3_reg <= rclk_s2_reg;
    end
  end

  // Each rising edge of the counter clock becomes a one-cycle enable
  assign rtc_tick = rclk_s2_reg & ~rclk_s3_reg;

  // --------------------------------------------------------------------------
  // Register write and read decode
  // --------------------------------------------------------------------------
  wire wr_control_a  = reg_wr && (reg_addr == `RPE_OFS_CONTROL_A);
  wire wr_inten  = reg_wr && (reg_addr == `RPE_OFS_INTEN);
  wire wr_flags  = reg_wr && (reg_addr == `RPE_OFS_COUNTER_IRQ_FLAGS);
  wire wr_dbg    = reg_wr && (reg_addr == `RPE_OFS_COUNTER_DEBUG_CONTROL);
  wire wr_cnt_lo = reg_wr && (reg_addr == `RPE_OFS_CNT_LO);
  wire wr_cnt_hi = reg_wr && (reg_addr == `RPE_OFS_CNT_HI);
  wire wr_per_lo = reg_wr && (reg_addr == `RPE_OFS_PER_LO);
  wire wr_per_hi = reg_wr && (reg_addr == `RPE_OFS_PER_HI);
  wire wr_cmp_lo = reg_wr && (reg_addr == `RPE_OFS_CMP_LO);
  wire wr_cmp_hi = reg_wr && (reg_addr == `RPE_OFS_CMP_HI);
  wire wr_tctrl  = reg_wr && (reg_addr == `RPE_OFS_TCTRL);
  wire wr_tinten = reg_wr && (reg_addr == `RPE_OFS_TINTEN);
  wire wr_tflags = reg_wr && (reg_addr == `RPE_OFS_TINTFLAGS);
  wire wr_tdbg   = reg_wr && (reg_addr == `RPE_OFS_TDBGCTRL);
  wire rd_cnt_lo = reg_rd && (reg_addr == `RPE_OFS_CNT_LO);
  wire rd_per_lo = reg_rd && (reg_addr == `RPE_OFS_PER_LO);
  wire rd_cmp_lo = reg_rd && (reg_addr == `RPE_OFS_CMP_LO);
  wire wr_lo     = wr_cnt_lo | wr_per_lo | wr_cmp_lo;

  // --------------------------------------------------------------------------
  // Bus-side shadows and the counter-side copies they feed
  // --------------------------------------------------------------------------
  logic [7:0]       control_a_sh_reg;
  logic [7:0]       control_a_act_reg;
  logic [CNT_W-1:0] cnt_sh_reg;
  logic [CNT_W-1:0] per_sh_reg;
  logic [CNT_W-1:0] per_act_reg;
  logic [CNT_W-1:0] cmp_sh_reg;
  logic [CNT_W-1:0] cmp_act_reg;
  logic [7:0]       tctrl_sh_reg;
  logic [7:0]       tctrl_act_reg;
  logic [7:0]       temp_reg;
  logic [1:0]       counter_irq_enables;
  logic [1:0]       counter_irq_flags;
  logic             tick_irq_enables;
  logic             tick_irq_flags;
  logic             counter_debug_control;
  logic             tick_debug_control;
  logic [CNT_W-1:0] count_register;

  // High byte commits the word with the low byte held in the temporary
  wire [CNT_W-1:0] word_wr = {reg_wdata, temp_reg};

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      control_a_sh_reg <= `RPE_CONTROL_A_RST;
      cnt_sh_reg   <= '0;
      per_sh_reg   <= `RPE_PER_RST;
      cmp_sh_reg   <= `RPE_CMP_RST;
      tctrl_sh_reg <= `RPE_TCTRL_RST;
      temp_reg     <= 8'h00;
    end else begin
      if (wr_control_a)  control_a_sh_reg <= reg_wdata;
      if (wr_cnt_hi) cnt_sh_reg   <= word_wr;
      if (wr_per_hi) per_sh_reg   <= word_wr;
      if (wr_cmp_hi) cmp_sh_reg   <= word_wr;
      if (wr_tctrl)  tctrl_sh_reg <= reg_wdata;
      if (wr_lo)
        temp_reg <= reg_wdata;
      else if (rd_cnt_lo)
        temp_reg <= count_register[15:8];
      else if (rd_per_lo)
        temp_reg <= per_act_reg[15:8];
      else if (rd_cmp_lo)
        temp_reg <= cmp_act_reg[15:8];
    end
  end

  // --------------------------------------------------------------------------
  // Synchronisation busy tracking
  // --------------------------------------------------------------------------
  // A write arms a count of counter-clock edges; the copy moves at the last one
  logic [1:0] sync_cnt_reg [5];
  logic [4:0] sync_start;
  logic [4:0] sync_busy;
  logic [4:0] sync_apply;

  assign sync_start = {wr_tctrl, wr_cmp_hi, wr_per_hi, wr_cnt_hi, wr_control_a};

  for (genvar i = 0; i < 5; i++) begin : g_sync
    assign sync_busy[i]  = (sync_cnt_reg[i] != 2'h0);
    assign sync_apply[i] = rtc_tick && (sync_cnt_reg[i] == 2'h1) && !sync_start[i];

    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn)
        sync_cnt_reg[i] <= 2'h0;
      else if (sync_start[i])
        sync_cnt_reg[i] <= `RPE_SYNC_TICKS;
      else if (rtc_tick && sync_busy[i])
        sync_cnt_reg[i] <= sync_cnt_reg[i] - 2'h1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      control_a_act_reg <= `RPE_CONTROL_A_RST;
      per_act_reg   <= `RPE_PER_RST;
      cmp_act_reg   <= `RPE_CMP_RST;
      tctrl_act_reg <= `RPE_TCTRL_RST;
    end else begin
      if (sync_apply[RPE_SY_CONTROL_A]) control_a_act_reg <= control_a_sh_reg;
      if (sync_apply[RPE_SY_PER])   per_act_reg   <= per_sh_reg;
      if (sync_apply[RPE_SY_CMP])   cmp_act_reg   <= cmp_sh_reg;
      if (sync_apply[RPE_SY_TICK])  tctrl_act_reg <= tctrl_sh_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Prescaler and run conditions
  // --------------------------------------------------------------------------
  logic [PRE_W-1:0] presc_reg;

  wire       rtc_en    = control_a_act_reg[`RPE_CONTROL_A_EN];
  wire       tick_en   = tctrl_act_reg[`RPE_TCTRL_EN];
  wire [3:0] pre_sel   = control_a_act_reg[`RPE_CONTROL_A_PRE_MSB:`RPE_CONTROL_A_PRE_LSB];
  wire [3:0] tick_code = tctrl_act_reg[`RPE_TCTRL_PER_MSB:`RPE_TCTRL_PER_LSB];
  wire       presc_run = rtc_en | tick_en;
  // The tick timer ignores sleep entirely; only the counter obeys standby
  wire       stdby_blk = power_state.standby && !control_a_act_reg[`RPE_CONTROL_A_STDBY];
  wire       halt_blk  = power_state.halted && !counter_debug_control;
  wire       cnt_run   = rtc_en && !stdby_blk && !halt_blk;

  wire [15:0]      mask16    = (16'h0001 << pre_sel) - 16'h0001;
  wire [PRE_W-1:0] pre_mask  = mask16[PRE_W-1:0];
  wire             count_en  = rtc_tick && presc_run && ((presc_reg & pre_mask) == pre_mask);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      presc_reg <= '0;
    else if (!presc_run)
      presc_reg <= '0;
    else if (rtc_tick)
      presc_reg <= presc_reg + 1'b1;
  end

  // --------------------------------------------------------------------------
  // Counter, wrap and compare
  // --------------------------------------------------------------------------
  wire wrap_hit = count_en && cnt_run && (count_register == per_act_reg);
  wire cmp_hit  = count_en && cnt_run && (count_register == cmp_act_reg);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      count_register <= '0;
    else if (sync_apply[RPE_SY_CNT])
      count_register <= cnt_sh_reg;
    else if (wrap_hit)
      count_register <= '0;
    else if (count_en && cnt_run)
      count_register <= count_register + 1'b1;
  end

  // --------------------------------------------------------------------------
  // Periodic tick timer output
  // --------------------------------------------------------------------------
  logic tick_out_q_reg;

  wire tick_code_ok = (tick_code >= `RPE_TICK_CODE_MIN) && (tick_code <= `RPE_TICK_CODE_MAX);
  // Prescaler bit n toggles every 2^n edges, so the full period is 2^(n+1)
  wire tick_raw     = tick_en && tick_code_ok && presc_reg[tick_code];
  wire tick_halt    = power_state.halted && !tick_debug_control;
  wire tick_out     = tick_raw && !tick_halt;
  wire tick_rise    = tick_out && !tick_out_q_reg;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      tick_out_q_reg <= 1'b0;
    else
      tick_out_q_reg <= tick_out;
  end

  // --------------------------------------------------------------------------
  // Flags, enables and debug controls
  // --------------------------------------------------------------------------
  wire [1:0] flags_clr  = wr_flags ? reg_wdata[1:0] : 2'h0;
  wire [1:0] flags_set  = {cmp_hit, wrap_hit};
  wire       tflag_clr  = wr_tflags && reg_wdata[`RPE_TFLAG_TICK];

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      counter_irq_enables   <= 2'h0;
      counter_irq_flags     <= 2'h0;
      tick_irq_enables      <= 1'b0;
      tick_irq_flags        <= 1'b0;
      counter_debug_control <= 1'b0;
      tick_debug_control    <= 1'b0;
    end else begin
      if (wr_inten)  counter_irq_enables   <= reg_wdata[1:0];
      if (wr_tinten) tick_irq_enables      <= reg_wdata[0];
      if (wr_dbg)    counter_debug_control <= reg_wdata[`RPE_DBG_RUN];
      if (wr_tdbg)   tick_debug_control    <= reg_wdata[`RPE_DBG_RUN];
      // A set in the clearing cycle survives
      counter_irq_flags <= (counter_irq_flags & ~flags_clr) | flags_set;
      tick_irq_flags    <= (tick_irq_flags & ~tflag_clr) | tick_rise;
    end
  end

  assign counter_irq = |(counter_irq_flags & counter_irq_enables);
  assign tick_irq    = tick_irq_flags & tick_irq_enables;

  // --------------------------------------------------------------------------
  // Events
  // --------------------------------------------------------------------------
  logic       wrap_ev_reg;
  logic       cmp_ev_reg;
  logic [7:0] levels_reg;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wrap_ev_reg <= 1'b0;
      cmp_ev_reg  <= 1'b0;
      levels_reg  <= 8'h00;
    end else begin
      // Held from one counter-clock edge to the next
      if (rtc_tick) begin
        wrap_ev_reg <= wrap_hit;
        cmp_ev_reg  <= cmp_hit;
      end
      levels_reg <= tick_en ? presc_reg[`RPE_LEVEL_LSB +: 8] : 8'h00;
    end
  end

  assign events.wrap_event    = wrap_ev_reg;
  assign events.compare_match = cmp_ev_reg;
  assign events.tick_levels   = levels_reg;

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  logic [7:0] rd_mux;
  logic [7:0] rdata_reg;

  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      `RPE_OFS_CONTROL_A:     rd_mux = control_a_sh_reg;
      `RPE_OFS_STATUS:    rd_mux = {4'h0, sync_busy[3:0]};
      `RPE_OFS_INTEN:     rd_mux = {6'h00, counter_irq_enables};
      `RPE_OFS_COUNTER_IRQ_FLAGS:  rd_mux = {6'h00, counter_irq_flags};
      `RPE_OFS_COUNTER_DEBUG_CONTROL:   rd_mux = {7'h00, counter_debug_control};
      `RPE_OFS_CNT_LO:    rd_mux = count_register[7:0];
      `RPE_OFS_PER_LO:    rd_mux = per_act_reg[7:0];
      `RPE_OFS_CMP_LO:    rd_mux = cmp_act_reg[7:0];
      `RPE_OFS_CNT_HI,
      `RPE_OFS_PER_HI,
      `RPE_OFS_CMP_HI:    rd_mux = temp_reg;
      `RPE_OFS_TCTRL:     rd_mux = tctrl_sh_reg;
      `RPE_OFS_TSTATUS:   rd_mux = {7'h00, sync_busy[RPE_SY_TICK]};
      `RPE_OFS_TINTEN:    rd_mux = {7'h00, tick_irq_enables};
      `RPE_OFS_TINTFLAGS: rd_mux = {7'h00, tick_irq_flags};
      `RPE_OFS_TDBGCTRL:  rd_mux = {7'h00, tick_debug_control};
      default:            rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= reg_rd ? rd_mux : 8'h00;
  end

  assign reg_rdata = rdata_reg;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  chk_wrap_flag: assert property (@(posedge mclk) disable iff (!rstn)
    wrap_hit |=> counter_irq_flags[`RPE_FLAG_WRAP] && wrap_ev_reg)
    else $error("wrap did not set flag and event together");

  chk_wrap_zero: assert property (@(posedge mclk) disable iff (!rstn)
    wrap_hit && !sync_apply[RPE_SY_CNT] |=> count_register == '0)
    else $error("count did not return to zero on wrap");

  chk_cmp_event: assert property (@(posedge mclk) disable iff (!rstn)
    cmp_hit |=> cmp_ev_reg && counter_irq_flags[`RPE_FLAG_CMP])
    else $error("compare event or flag missing");

  chk_event_hold: assert property (@(posedge mclk) disable iff (!rstn)
    wrap_ev_reg && !rtc_tick |=> wrap_ev_reg)
    else $error("wrap event ended before next counter edge");

  chk_irq_stays: assert property (@(posedge mclk) disable iff (!rstn)
    counter_irq && !wr_flags && !wr_inten |=> counter_irq)
    else $error("counter request dropped without clear");

  chk_tick_flag: assert property (@(posedge mclk) disable iff (!rstn)
    tick_rise |=> tick_irq_flags)
    else $error("tick rising edge did not set flag");

  chk_halt_low: assert property (@(posedge mclk) disable iff (!rstn)
    tick_halt |=> !tick_out_q_reg)
    else $error("tick output not low while halted");

  chk_tbusy_set: assert property (@(posedge mclk) disable iff (!rstn)
    wr_tctrl |=> sync_busy[RPE_SY_TICK] && !(tctrl_act_reg != $past(tctrl_act_reg)))
    else $error("tick control write not held busy");

  chk_cnt_stop: assert property (@(posedge mclk) disable iff (!rstn)
    halt_blk && !sync_apply[RPE_SY_CNT] |=> $stable(count_register))
    else $error("counter moved during debug halt");

endmodule : rpe_core

// ===== sim/rpe_pulse_meter.sv
// Event sink model: counts pulses on one event line, measures width and spacing
`timescale 1ns/1ps

module rpe_pulse_meter (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rstn,
  // Observed event line
  input  wire logic pulse,
  // Measurements
  output int        count,
  output int        len,
  output time       rise_t,
  output time       gap
);
  logic pulse_q;
  int   run;

  // Sampled on mclk like a synchronous event user; width is counted in mclk cycles
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pulse_q <= 1'b0;
      count   <= 0;
      len     <= 0;
      run     <= 0;
      rise_t  <= 0;
      gap     <= 0;
    end else begin
      pulse_q <= pulse;
      if (pulse && !pulse_q) begin
        count  <= count + 1;
        gap    <= $time - rise_t;
        rise_t <= $time;
        run    <= 1;
      end else if (pulse) begin
        run <= run + 1;
      end
      if (!pulse && pulse_q) begin
        len <= run;
      end
    end
  end
endmodule : rpe_pulse_meter

// ===== sim/rtc_pit_event_irq_sync_bench.sv
// Self-checking bench for the counter and tick timer block
`timescale 1ns/1ps
`include "rpe_regs.svh"

module rtc_pit_event_irq_sync_bench
  import rpe_pkg::*;
;
  localparam time TICK = 80;
  logic       mclk, rstn, counter_clk_pin, reg_wr, reg_rd, counter_irq, tick_irq;
  rpe_power_t power_state;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd_val;
  rpe_event_t events;
  int         err_total, checks_done, n, code;
  int         wrap_count, wrap_len, cmp_count, cmp_len, lvl_count, lvl_len;
  time        wrap_rise, wrap_gap, cmp_rise, cmp_gap, lvl_rise, lvl_gap, t_a, t_b;

  rpe_core u_rpe_core (.mclk(mclk), .rstn(rstn), .counter_clk_pin(counter_clk_pin),
    .power_state(power_state), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .counter_irq(counter_irq), .tick_irq(tick_irq),
    .events(events));
  rpe_pulse_meter u_rpe_pulse_meter_wrap (.mclk(mclk), .rstn(rstn), .pulse(events.wrap_event),
    .count(wrap_count), .len(wrap_len), .rise_t(wrap_rise), .gap(wrap_gap));
  rpe_pulse_meter u_rpe_pulse_meter_cmp (.mclk(mclk), .rstn(rstn), .pulse(events.compare_match),
    .count(cmp_count), .len(cmp_len), .rise_t(cmp_rise), .gap(cmp_gap));
  rpe_pulse_meter u_rpe_pulse_meter_lvl (.mclk(mclk), .rstn(rstn), .pulse(events.tick_levels[0]),
    .count(lvl_count), .len(lvl_len), .rise_t(lvl_rise), .gap(lvl_gap));

  // ---------------------------------------------------------------------------
  // Clocks: counter clock free-running at 80 ns, phase unrelated to mclk
  // ---------------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    counter_clk_pin = 1'b0;
    #13;
    forever #40 counter_clk_pin = ~counter_clk_pin;
  end

  // ---------------------------------------------------------------------------
  // Register port tasks and checks
  // ---------------------------------------------------------------------------
  task automatic complete_run();
    $display("Comparisons made: %0d, mismatches: %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s saw %0h, expected %0h", $time, what, got, exp);
    end
  endtask : check

  task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [5:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    // Data launched at the sampling edge stand until the next edge, so stimulus stays edge-aligned
    @(posedge mclk);
    d = reg_rdata;
  endtask : reg_read

  task automatic read_check(input logic [5:0] a, input logic [7:0] exp, input string what);
    reg_read(a, rd_val);
    check(rd_val, exp, what);
  endtask : read_check

  // Polls a status bit; a bound that runs out ends the run
  task automatic wait_bit(input logic [5:0] a, input int b, input logic v);
    int k;
    k = 0;
    reg_read(a, rd_val);
    while (rd_val[b] !== v && k < 60) begin
      reg_read(a, rd_val);
      k++;
    end
    if (rd_val[b] !== v) begin
      err_total++;
      $display("mismatch at %0t: wait on offset %0h timed out", $time, a);
      complete_run();
    end
  endtask : wait_bit

  // Synchronised write: busy must show at once, then clear before the next write
  task automatic sync_write(input logic [5:0] a, input logic [7:0] d, input logic [5:0] sa,
                            input int b);
    reg_write(a, d);
    reg_read(sa, rd_val);
    check(rd_val[b], 1'b1, "sync busy set");
    wait_bit(sa, b, 1'b0);
  endtask : sync_write

  task automatic wait_tick_irq(output time t);
    int k;
    k = 0;
    while (tick_irq !== 1'b1 && k < 4000) begin
      @(posedge mclk);
      k++;
    end
    if (tick_irq !== 1'b1) begin
      err_total++;
      $display("mismatch at %0t: tick request never came", $time);
      complete_run();
    end
    t = $time;
  endtask : wait_tick_irq

  task automatic clear_tick();
    reg_write(`RPE_OFS_TINTFLAGS, 8'h01);
    repeat (3) @(posedge mclk);
  endtask : clear_tick

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    power_state = 3'h0;
    err_total = 0;
    checks_done = 0;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    read_check(`RPE_OFS_CONTROL_A, `RPE_CONTROL_A_RST, "control reset");
    read_check(`RPE_OFS_PER_LO, 8'hFF, "wrap limit low reset");
    read_check(`RPE_OFS_PER_HI, 8'hFF, "wrap limit high reset");
    read_check(`RPE_OFS_CMP_LO, 8'h00, "compare reset");
    read_check(`RPE_OFS_TCTRL, `RPE_TCTRL_RST, "tick control reset");
    read_check(6'h07, 8'h00, "unmapped offset");
    // Wrap limit 3, compare 1, only the wrap interrupt enabled
    reg_write(`RPE_OFS_PER_LO, 8'h03);
    sync_write(`RPE_OFS_PER_HI, 8'h00, `RPE_OFS_STATUS, 2);
    reg_write(`RPE_OFS_CMP_LO, 8'h01);
    sync_write(`RPE_OFS_CMP_HI, 8'h00, `RPE_OFS_STATUS, 3);
    reg_write(`RPE_OFS_CNT_LO, 8'h00);
    sync_write(`RPE_OFS_CNT_HI, 8'h00, `RPE_OFS_STATUS, 1);
    reg_write(`RPE_OFS_INTEN, 8'h01);
    sync_write(`RPE_OFS_CONTROL_A, 8'h01, `RPE_OFS_STATUS, 0);
    repeat (200) @(posedge mclk);
    check(wrap_len, 8, "wrap event width");
    check(cmp_len, 8, "compare event width");
    check(wrap_gap, 4 * TICK, "wrap spacing");
    check(cmp_gap, 4 * TICK, "compare spacing");
    check((wrap_rise > cmp_rise) ? wrap_rise - cmp_rise : cmp_rise - wrap_rise,
          2 * TICK, "wrap to compare offset");
    check(counter_irq, 1'b1, "counter request");
    read_check(`RPE_OFS_COUNTER_IRQ_FLAGS, 8'h03, "flags incl. disabled compare");
    // Standby stops the counter unless run-in-standby is set
    power_state.standby <= 1'b1;
    repeat (20) @(posedge mclk);
    n = wrap_count;
    repeat (200) @(posedge mclk);
    check(wrap_count, n, "halted in standby");
    sync_write(`RPE_OFS_CONTROL_A, 8'h81, `RPE_OFS_STATUS, 0);
    n = wrap_count;
    repeat (200) @(posedge mclk);
    check(wrap_count - n >= 6, 1'b1, "runs in standby");
    power_state.standby <= 1'b0;
    power_state.idle <= 1'b1;
    n = wrap_count;
    repeat (200) @(posedge mclk);
    check(wrap_count - n >= 6, 1'b1, "runs in idle");
    // Debug halt with and without keep-running
    power_state.idle <= 1'b0;
    power_state.halted <= 1'b1;
    repeat (20) @(posedge mclk);
    n = wrap_count;
    repeat (200) @(posedge mclk);
    check(wrap_count, n, "stopped while halted");
    reg_write(`RPE_OFS_COUNTER_DEBUG_CONTROL, 8'h01);
    n = wrap_count;
    repeat (200) @(posedge mclk);
    check(wrap_count - n >= 6, 1'b1, "runs while halted");
    power_state.halted <= 1'b0;
    // Request holds until its own flag is cleared
    sync_write(`RPE_OFS_CONTROL_A, 8'h00, `RPE_OFS_STATUS, 0);
    repeat (20) @(posedge mclk);
    reg_write(`RPE_OFS_COUNTER_IRQ_FLAGS, 8'h02);
    repeat (2) @(posedge mclk);
    check(counter_irq, 1'b1, "request held by wrap flag");
    read_check(`RPE_OFS_COUNTER_IRQ_FLAGS, 8'h01, "compare flag cleared");
    check(tick_irq, 1'b0, "tick vector idle");
    reg_write(`RPE_OFS_COUNTER_IRQ_FLAGS, 8'h01);
    repeat (2) @(posedge mclk);
    check(counter_irq, 1'b0, "request dropped");
    // Counter stopped: a paired count write lands whole and reads back
    reg_write(`RPE_OFS_CNT_LO, 8'h34);
    sync_write(`RPE_OFS_CNT_HI, 8'h12, `RPE_OFS_STATUS, 1);
    read_check(`RPE_OFS_CNT_LO, 8'h34, "count low byte");
    read_check(`RPE_OFS_CNT_HI, 8'h12, "count high byte");
    // Tick timer periods, run in standby
    reg_write(`RPE_OFS_TINTEN, 8'h01);
    power_state.standby <= 1'b1;
    for (code = 1; code <= 3; code++) begin
      sync_write(`RPE_OFS_TCTRL, 8'((code << `RPE_TCTRL_PER_LSB) | 1), `RPE_OFS_TSTATUS, 0);
      wait_tick_irq(t_a);
      clear_tick();
      wait_tick_irq(t_a);
      clear_tick();
      wait_tick_irq(t_b);
      check(t_b - t_a, (64'd1 << (code + 1)) * TICK, "tick period");
      clear_tick();
    end
    repeat (1100) @(posedge mclk);
    check(lvl_gap, 64 * TICK, "level event period");
    check(lvl_len, 256, "level event high time");
    // Break while the tick output is high gives one extra flag
    sync_write(`RPE_OFS_TCTRL, 8'h09, `RPE_OFS_TSTATUS, 0);
    clear_tick();
    wait_tick_irq(t_a);
    reg_write(`RPE_OFS_TINTFLAGS, 8'h01);
    power_state.halted <= 1'b1;
    read_check(`RPE_OFS_TINTFLAGS, 8'h00, "output forced low");
    power_state.halted <= 1'b0;
    repeat (4) @(posedge mclk);
    read_check(`RPE_OFS_TINTFLAGS, 8'h01, "extra flag on restart");
    // Break while the output is low resumes quietly
    clear_tick();
    wait_tick_irq(t_a);
    reg_write(`RPE_OFS_TINTFLAGS, 8'h01);
    repeat (14) @(posedge mclk);
    power_state.halted <= 1'b1;
    repeat (3) @(posedge mclk);
    power_state.halted <= 1'b0;
    read_check(`RPE_OFS_TINTFLAGS, 8'h00, "no extra flag");
    // Keep-running set: the tick timer goes on flagging while halted
    reg_write(`RPE_OFS_TDBGCTRL, 8'h01);
    power_state.halted <= 1'b1;
    clear_tick();
    wait_tick_irq(t_a);
    check(tick_irq, 1'b1, "tick runs while halted");
    complete_run();
  end
endmodule : rtc_pit_event_irq_sync_bench
